/* File: rtl/adc_ctl_pkg.sv */
// register map, field positions and trigger selectors of the converter control block
// used by the control module, its property checker and the testbench
package adc_ctl_pkg;
    // byte addresses on the apb side
    localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    // control register fields
    localparam int DONE_BIT = 0;
    localparam int SAMPLE_BIT = 1;
    localparam int AUTO_BIT = 2;
    localparam int SIMSEL_BIT = 3;
    localparam int GROUP_BIT = 4;
    localparam int CODE_LSB = 5;
    localparam int CODE_W = 3;
    // mode register fields
    localparam int RES12_BIT = 0;
    localparam int CHCNT_LSB = 1;
    localparam int CHCNT_W = 2;
    localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;
    localparam logic [2:0] MODE_RESET = 3'h0;
    // conversion time in system cycles
    localparam int CONV_CYCLES = 14;
    // auto-convert internal counter sample time
    localparam int AUTO_SAMPLE_CYCLES = 3;
    // number of trigger inputs from producers
    localparam int TRIG_W = 16;
    // trigger input index map
    localparam int TRG_PWM1 = 0;
    localparam int TRG_PWM2 = 1;
    localparam int TRG_PWM3 = 2;
    localparam int TRG_GEN12 = 3;
    localparam int TRG_GEN13 = 4;
    localparam int TRG_GEN14 = 5;
    localparam int TRG_GEN15 = 6;
    localparam int TRG_CHARGE_TIME = 7;
    localparam int TRG_TIMER5 = 8;
    localparam int TRG_PWM_SPECIAL = 9;
    localparam int TRG_TIMER3 = 10;
    localparam int TRG_EXT_PIN = 11;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b11
    } conv_state_e;
endpackage : adc_ctl_pkg

/* File: rtl/adc_sample_convert_control.sv */
// sampling and conversion sequencer of the converter, with apb register slave
// assumes trigger producers give levels on any clock; analog front end obeys
// sample_out and convert_start_out, and reports end of conversion by a pulse
//
// Function
// - group one codes pick generator or pwm; code 7 reserved
// - group zero codes pick timers, pwm special, charge time, pin, auto counter, manual; code 5 reserved
// - simultaneous or sequential channel sampling
// - simultaneous bit reads zero in 12-bit
// - auto start resamples after conversion ends
// - sample enable shows sampling; software may set
// - manual clear or hardware clear ends sampling
// - done sets at end, clears at start
// - software zero clears done harmlessly
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module adc_sample_convert_control
    import adc_ctl_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES,
    parameter int AUTO_LEN = AUTO_SAMPLE_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [TRIG_W-1:0] trigger_in,
    input wire logic conv_end_in,
    output logic sample_out,
    output logic convert_start_out,
    output logic [3:0] sample_channels_out,
    output logic simultaneous_out
);
    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [CODE_W-1:0] trigger_code_select_q;
    logic trigger_group_select_q;
    logic simultaneous_sample_select_q;
    logic auto_sample_start_q;
    logic sample_enable_q;
    logic done_q;
    logic resolution_12bit_select_q;
    logic [CHCNT_W-1:0] channel_count_select_q;
    conv_state_e state_q;
    logic [7:0] count_q;
    logic [TRIG_W-1:0] trig_rise;
    logic conv_end_sync_q;
    logic conv_end_meta_q;
    logic conv_end_prev_q;
    logic conv_done_evt;
    logic wr_ctl;
    logic wr_mode;
    logic apb_access;
    logic mapped;
    logic sel_fire;
    logic sel_reserved;
    logic start_conv;
    logic sim_eff;

    trig_edge_sync #(
        .WIDTH(TRIG_W)
    ) u_trig_sync (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .async_in(trigger_in),
        .rise_out(trig_rise)
    );

    // end-of-conversion from analog side is asynchronous
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            conv_end_meta_q <= 1'b0;
            conv_end_sync_q <= 1'b0;
            conv_end_prev_q <= 1'b0;
        end
        else
        begin
            conv_end_meta_q <= conv_end_in;
            conv_end_sync_q <= conv_end_meta_q;
            conv_end_prev_q <= conv_end_sync_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, unmapped gives pslverr
    assign apb_access = psel_in && penable_in;
    assign mapped = (paddr_in == ADDR_CONTROL_ONE) || (paddr_in == ADDR_MODE)
        || (paddr_in == ADDR_STATUS);
    assign pready_out = 1'b1;
    assign pslverr_out = apb_access && !mapped;
    assign wr_ctl = apb_access && pwrite_in && (paddr_in == ADDR_CONTROL_ONE);
    assign wr_mode = apb_access && pwrite_in && (paddr_in == ADDR_MODE);

    assign sim_eff = simultaneous_sample_select_q && !resolution_12bit_select_q;

    always_comb
    begin
        prdata_out = 32'h0000_0000;
        if (psel_in && !pwrite_in)
        begin
            case (paddr_in)
                ADDR_CONTROL_ONE:
                begin
                    prdata_out[DONE_BIT] = done_q;
                    prdata_out[SAMPLE_BIT] = sample_enable_q;
                    prdata_out[AUTO_BIT] = auto_sample_start_q;
                    prdata_out[SIMSEL_BIT] = sim_eff;
                    prdata_out[GROUP_BIT] = trigger_group_select_q;
                    prdata_out[CODE_LSB +: CODE_W] = trigger_code_select_q;
                end
                ADDR_MODE:
                begin
                    prdata_out[RES12_BIT] = resolution_12bit_select_q;
                    prdata_out[CHCNT_LSB +: CHCNT_W] = channel_count_select_q;
                end
                ADDR_STATUS:
                begin
                    prdata_out[1:0] = state_q;
                end
                default:
                begin
                    prdata_out = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            trigger_code_select_q <= CONTROL_ONE_RESET[CODE_LSB +: CODE_W];
            trigger_group_select_q <= CONTROL_ONE_RESET[GROUP_BIT];
            simultaneous_sample_select_q <= CONTROL_ONE_RESET[SIMSEL_BIT];
            auto_sample_start_q <= CONTROL_ONE_RESET[AUTO_BIT];
        end
        else if (wr_ctl)
        begin
            trigger_code_select_q <= pwdata_in[CODE_LSB +: CODE_W];
            trigger_group_select_q <= pwdata_in[GROUP_BIT];
            simultaneous_sample_select_q <= pwdata_in[SIMSEL_BIT];
            auto_sample_start_q <= pwdata_in[AUTO_BIT];
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            resolution_12bit_select_q <= MODE_RESET[RES12_BIT];
            channel_count_select_q <= MODE_RESET[CHCNT_LSB +: CHCNT_W];
        end
        else if (wr_mode)
        begin
            resolution_12bit_select_q <= pwdata_in[RES12_BIT];
            channel_count_select_q <= pwdata_in[CHCNT_LSB +: CHCNT_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trigger selection
    // group and code form one selector
    always_comb
    begin
        sel_fire = 1'b0;
        sel_reserved = 1'b0;
        case ({trigger_group_select_q, trigger_code_select_q})
            4'hF: sel_reserved = 1'b1;
            4'hE: sel_fire = trig_rise[TRG_GEN15];
            4'hD: sel_fire = trig_rise[TRG_GEN14];
            4'hC: sel_fire = trig_rise[TRG_GEN13];
            4'hB: sel_fire = trig_rise[TRG_GEN12];
            4'hA: sel_fire = trig_rise[TRG_PWM3];
            4'h9: sel_fire = trig_rise[TRG_PWM2];
            4'h8: sel_fire = trig_rise[TRG_PWM1];
            4'h7: sel_fire = (count_q >= 8'(AUTO_LEN));
            4'h6: sel_fire = trig_rise[TRG_CHARGE_TIME];
            4'h5: sel_reserved = 1'b1;
            4'h4: sel_fire = trig_rise[TRG_TIMER5];
            4'h3: sel_fire = trig_rise[TRG_PWM_SPECIAL];
            4'h2: sel_fire = trig_rise[TRG_TIMER3];
            4'h1: sel_fire = trig_rise[TRG_EXT_PIN];
            // manual mode: software writes sample enable low
            4'h0: sel_fire = wr_ctl && !pwdata_in[SAMPLE_BIT];
            default: sel_fire = 1'b0;
        endcase
    end

    assign start_conv = (state_q == ST_SAMPLE) && sel_fire && !sel_reserved;

    ////////////////////////////////////////////////////////////////////////
    // sequencer; conversion ends on analog pulse or on internal timeout
    assign conv_done_evt = (state_q == ST_CONVERT)
        && ((conv_end_sync_q && !conv_end_prev_q) || (count_q >= 8'(CONV_LEN)));

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            state_q <= ST_IDLE;
            sample_enable_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    // auto start sets sample enable itself
                    // software write of one starts sampling
                    if (auto_sample_start_q || (wr_ctl && pwdata_in[SAMPLE_BIT]))
                    begin
                        state_q <= ST_SAMPLE;
                        sample_enable_q <= 1'b1;
                    end
                end
                ST_SAMPLE:
                begin
                    // hardware clears sample enable on trigger
                    if (start_conv)
                    begin
                        state_q <= ST_CONVERT;
                        sample_enable_q <= 1'b0;
                    end
                end
                ST_CONVERT:
                begin
                    if (conv_done_evt)
                    begin
                        state_q <= auto_sample_start_q ? ST_SAMPLE : ST_IDLE;
                        sample_enable_q <= auto_sample_start_q;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    sample_enable_q <= 1'b0;
                end
            endcase
        end
    end

    // shared counter: sample time in ST_SAMPLE (used by auto-convert), conversion time in ST_CONVERT
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in || start_conv || conv_done_evt || state_q == ST_IDLE)
        begin
            count_q <= 8'h00;
        end
        else if (count_q != 8'hFF)
        begin
            count_q <= count_q + 8'h01;
        end
    end

    // done set at end, cleared at start
    // software zero clears; set wins over clear
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            done_q <= CONTROL_ONE_RESET[DONE_BIT];
        end
        else if (conv_done_evt)
        begin
            done_q <= 1'b1;
        end
        else if (start_conv || (wr_ctl && !pwdata_in[DONE_BIT]))
        begin
            done_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // front end outputs
    // four, two or one channel; sampled together only when the simultaneous bit holds
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            sample_channels_out <= 4'h1;
            simultaneous_out <= 1'b0;
            convert_start_out <= 1'b0;
        end
        else
        begin
            convert_start_out <= start_conv;
            simultaneous_out <= sim_eff && (channel_count_select_q != 2'h0);
            if (channel_count_select_q[1])
            begin
                sample_channels_out <= 4'hF;
            end
            else if (channel_count_select_q[0])
            begin
                sample_channels_out <= 4'h3;
            end
            else
            begin
                sample_channels_out <= 4'h1;
            end
        end
    end

    assign sample_out = sample_enable_q;
endmodule : adc_sample_convert_control

/* File: rtl/trig_edge_sync.sv */
// two-flop synchroniser and rising edge detector for trigger inputs
// assumes triggers are levels from other clock domains or pins
`timescale 1ns/1ps
module trig_edge_sync #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] rise_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise_out = sync_q & ~prev_q;
endmodule : trig_edge_sync

/* File: sim/adc_ctl_properties.sv */
// port checker for the converter control block, bound into its top module
// assumes apb writes take effect at the access edge, zero wait states
`timescale 1ns/1ps
module adc_ctl_properties
    import adc_ctl_pkg::*;
#(
    parameter int CONV_LEN = 14,
    parameter int AUTO_LEN = 3
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [TRIG_W-1:0] trigger_in,
    input wire logic conv_end_in,
    input wire logic sample_out,
    input wire logic convert_start_out,
    input wire logic [3:0] sample_channels_out,
    input wire logic simultaneous_out
);
    logic acc, wr_ctl, rd_ctl, rsvd;
    logic [5:0] ctl_q;
    logic [2:0] mode_q;
    logic [1:0] quiet_q;
    assign acc = psel_in && penable_in;
    assign wr_ctl = acc && pwrite_in && paddr_in == ADDR_CONTROL_ONE;
    assign rd_ctl = acc && !pwrite_in && paddr_in == ADDR_CONTROL_ONE;
    assign rsvd = {ctl_q[2], ctl_q[5:3]} inside {4'h5, 4'hF};
    // shadow of the fields that shape the outputs
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            ctl_q <= 6'h00;
            mode_q <= 3'h0;
        end
        else if (wr_ctl)
            ctl_q <= pwdata_in[7:2];
        else if (acc && pwrite_in && paddr_in == ADDR_MODE)
            mode_q <= pwdata_in[2:0];
    end
    // outputs lag a write by two registers, so judge them only once settled
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in || (acc && pwrite_in))
            quiet_q <= 2'h0;
        else if (quiet_q != 2'h3)
            quiet_q <= quiet_q + 2'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);
    AST_SAMPLE_READ:
    assert property (rd_ctl |-> prdata_out[SAMPLE_BIT] == sample_out)
        else $error("sample bit read differs from sample line");
    AST_SIMUL_MASKED:
    assert property (rd_ctl && mode_q[0] |-> !prdata_out[SIMSEL_BIT])
        else $error("simultaneous bit reads one in 12-bit mode");
    AST_CHANNELS:
    assert property (quiet_q == 2'h3 |->
        sample_channels_out == (mode_q[2] ? 4'hF : (mode_q[1] ? 4'h3 : 4'h1)))
        else $error("channel set wrong");
    AST_SIMUL:
    assert property (quiet_q == 2'h3 |->
        simultaneous_out == (ctl_q[1] && !mode_q[0] && mode_q[2:1] != 2'h0))
        else $error("simultaneous flag wrong");
    // manual mode is judged on the selector held before the write lands
    AST_MANUAL_END:
    assert property (wr_ctl && ctl_q[5:2] == 4'h0 && !pwdata_in[SAMPLE_BIT] && sample_out
        |=> !sample_out)
        else $error("manual clear did not end sampling");
    AST_FELL_START:
    assert property ($fell(sample_out) |-> ##[0:2] convert_start_out)
        else $error("sampling ended without conversion start");
    AST_START_PULSE:
    assert property (convert_start_out |=> !convert_start_out)
        else $error("start pulse longer than one cycle");
    AST_HOLD_ON_START:
    assert property (convert_start_out |-> !sample_out)
        else $error("still sampling at conversion start");
    AST_RESERVED:
    assert property (rsvd [*4] |-> !convert_start_out)
        else $error("reserved selector started a conversion");
    AST_AUTO_RESAMPLE:
    assert property ($rose(conv_end_in) && ctl_q[0] ##4 ctl_q[0] |-> ##[0:4] sample_out)
        else $error("auto start did not resume sampling");
endmodule : adc_ctl_properties

bind adc_sample_convert_control adc_ctl_properties #(
    .CONV_LEN(CONV_LEN),
    .AUTO_LEN(AUTO_LEN)
) adc_ctl_properties_i (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .trigger_in(trigger_in), .conv_end_in(conv_end_in),
    .sample_out(sample_out), .convert_start_out(convert_start_out),
    .sample_channels_out(sample_channels_out), .simultaneous_out(simultaneous_out)
);

/* File: sim/adc_front_end_model.sv */
// behavioural analog front end: answers each conversion start with an end pulse
// assumes convert_start_in is a one-cycle pulse on the system clock
`timescale 1ns/1ps
module adc_front_end_model #(
    parameter int FAST = 5,
    parameter int SLOW = 20
) (
    input wire logic clk_sys_in,
    input wire logic convert_start_in,
    input wire logic slow_in,
    output logic conv_end_out
);
    int cnt_q = 0;
    initial conv_end_out = 1'b0;
    // slow answer outlasts the block's own conversion count
    always @(posedge clk_sys_in)
    begin
        if (convert_start_in)
            cnt_q <= slow_in ? SLOW : FAST;
        else if (cnt_q > 0)
            cnt_q <= cnt_q - 1;
        conv_end_out <= cnt_q inside {1, 2};
    end
endmodule : adc_front_end_model

/* File: sim/testbench.sv */
// scenario bench for the converter control block over apb
// assumes zero-wait apb slave and the front end model on the conversion side
`timescale 1ns/1ps
module testbench;
    import adc_ctl_pkg::*;
    logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, slow = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, ev;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [TRIG_W-1:0] trig = '0;
    logic conv_end, conv_start, simul, sample_enable;
    logic [3:0] chans;
    int bad_count = 0, check_count = 0, cycles = 0;
    adc_sample_convert_control adc_sample_convert_control_i (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .trigger_in(trig), .conv_end_in(conv_end), .sample_out(sample_enable),
        .convert_start_out(conv_start), .sample_channels_out(chans),
        .simultaneous_out(simul));
    adc_front_end_model adc_front_end_model_i (.clk_sys_in(clk_sys_in),
        .convert_start_in(conv_start), .slow_in(slow), .conv_end_out(conv_end));
    always #5 clk_sys_in = ~clk_sys_in;
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d bad %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x)
        begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, s, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do
            @(posedge clk_sys_in);
        while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_in);
    endtask : apb
    task automatic wait_st(input logic [1:0] st);
        repeat (60)
        begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            if (rv[1:0] === st)
                break;
        end
        chk(rv, {30'h0, st});
    endtask : wait_st
    task automatic pulse(input logic [TRIG_W-1:0] m);
        trig <= m;
        repeat (3) @(posedge clk_sys_in);
        trig <= '0;
        repeat (4) @(posedge clk_sys_in);
    endtask : pulse
    task automatic t_manual;
        slow <= 1'b1;
        apb(1'b0, 8'h0C, 32'h0);
        chk({rv[30:0], ev}, 32'h1);
        apb(1'b1, ADDR_CONTROL_ONE, 32'h2);
        apb(1'b0, ADDR_CONTROL_ONE, 32'h0);
        chk(rv, 32'h2);
        apb(1'b1, ADDR_CONTROL_ONE, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rv, 32'h3);
        wait_st(2'h0);
        apb(1'b0, ADDR_CONTROL_ONE, 32'h0);
        chk(rv, 32'h1);
        // the late end pulse must not land in the next conversion
        repeat (24) @(posedge clk_sys_in);
        apb(1'b1, ADDR_CONTROL_ONE, 32'h3);
        apb(1'b1, ADDR_CONTROL_ONE, 32'h1);
        apb(1'b0, ADDR_CONTROL_ONE, 32'h0);
        chk(rv, 32'h0);
        apb(1'b1, ADDR_CONTROL_ONE, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rv, 32'h3);
        wait_st(2'h0);
        apb(1'b1, ADDR_CONTROL_ONE, 32'h0);
        apb(1'b0, ADDR_CONTROL_ONE, 32'h0);
        chk(rv, 32'h0);
        slow <= 1'b0;
        $display("manual test done");
    endtask : t_manual
    task automatic t_sim;
        logic [3:0] v;
        for (int i = 0; i < 16; i++)
        begin
            v = 4'(i);
            apb(1'b1, ADDR_MODE, {29'h0, v[2:0]});
            apb(1'b1, ADDR_CONTROL_ONE, {28'h0, v[3], 3'h0});
            apb(1'b0, ADDR_CONTROL_ONE, 32'h0);
            chk(rv, {28'h0, v[3] & !v[0], 3'h0});
            chk({28'h0, chans}, v[2] ? 32'hF : (v[1] ? 32'h3 : 32'h1));
            chk({31'h0, simul}, {31'h0, v[3] & !v[0] & (v[2:1] != 2'h0)});
        end
        apb(1'b1, ADDR_MODE, 32'h0);
        $display("simultaneous test done");
    endtask : t_sim
    task automatic t_trig;
        int map [16];
        logic [TRIG_W-1:0] m;
        logic [31:0] sel;
        map = '{-2, 11, 10, 9, 8, -1, 7, -3, 0, 1, 2, 3, 4, 5, 6, -1};
        for (int s = 1; s < 16; s++)
        begin
            sel = {24'h0, 3'(s), 1'(s >> 3), 4'h0};
            m = '0;
            if (map[s] >= 0)
                m[map[s]] = 1'b1;
            apb(1'b1, ADDR_CONTROL_ONE, sel | 32'h2);
            pulse(~m);
            apb(1'b0, ADDR_STATUS, 32'h0);
            if (map[s] != -3)
                chk(rv, 32'h1);
            pulse(m);
            if (map[s] == -1)
            begin
                apb(1'b0, ADDR_STATUS, 32'h0);
                chk(rv, 32'h1);
                apb(1'b1, ADDR_CONTROL_ONE, 32'h2);
                apb(1'b1, ADDR_CONTROL_ONE, 32'h0);
            end
            wait_st(2'h0);
            apb(1'b0, ADDR_CONTROL_ONE, 32'h0);
            chk(rv, (map[s] == -1) ? 32'h1 : (sel | 32'h1));
        end
        $display("trigger test done");
    endtask : t_trig
    task automatic t_auto;
        int n;
        n = 0;
        apb(1'b1, ADDR_CONTROL_ONE, 32'hE4);
        repeat (100)
        begin
            @(posedge clk_sys_in);
            if (conv_start === 1'b1)
                n++;
        end
        chk(32'(n > 2), 32'h1);
        // done bit written as one so that it is left alone while auto start is turned off
        apb(1'b1, ADDR_CONTROL_ONE, 32'hE1);
        wait_st(2'h0);
        repeat (30) @(posedge clk_sys_in);
        chk({31'h0, sample_enable}, 32'h0);
        $display("auto test done");
    endtask : t_auto
    initial
    begin
        repeat (16) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_sys_in);
        t_manual();
        t_sim();
        t_trig();
        t_auto();
        close_out();
    end
endmodule : testbench
